// >>> kdui_pkg.sv
// Constants, types and helpers shared by the keypad display control
package kdui_pkg;
  localparam int KEY_N = 10;
  localparam int K_SET = 0;
  localparam int K_LOCATION_STEP_KEY = 1;
  localparam int K_UP = 2;
  localparam int K_DOWN = 3;
  localparam int K_LEFT = 4;
  localparam int K_UPSC = 5;
  localparam int K_ZERO = 6;
  localparam int K_NORM = 7;
  localparam int K_BGND = 8;
  localparam int K_AUDIT = 9;
  localparam int CHAR_N = 6;
  localparam int SEG_W = 7 * CHAR_N;

  // Display banks, Gray coded along the left-key cycle from U to A
  typedef enum logic [2:0] {
    BK_U = 3'b000,
    BK_S = 3'b001,
    BK_F = 3'b011,
    BK_C = 3'b010,
    BK_A = 3'b110
  } kdui_bank_t;

  // Slot indices inside the user and fundamental banks
  localparam logic [3:0] INSTANTANEOUS_SLOT = 4'h0;
  localparam logic [3:0] MINUTE_AVERAGE_SLOT = 4'h1;
  localparam logic [3:0] SELECTABLE_AVERAGE_SLOT = 4'h2;
  localparam logic [3:0] PRIMARY_STATUS_SLOT = 4'h3;
  localparam logic [3:0] AUDIT_MARKER_SLOT = 4'h4;

  // Encoder positions of the calibration mechanism
  localparam logic [1:0] POS_UNKNOWN = 2'h0;
  localparam logic [1:0] POS_NORMAL = 2'h1;
  localparam logic [1:0] POS_ZERO = 2'h2;
  localparam logic [1:0] POS_UPSCALE = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFS_LOC = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_EDIT = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_LAMP = 8'h10;
  localparam logic [7:0] OFS_MARK = 8'h14;
  localparam logic [7:0] OFS_TAG = 8'h18;
  localparam logic [7:0] OFS_STORE = 8'h1c;

  // Command flag positions
  localparam int CMD_STORE = 0;
  localparam int CMD_UPCAL = 1;
  localparam int CMD_ZCAL = 2;
  localparam int CMD_NORM = 3;
  localparam int CMD_ZSET = 4;
  localparam int CMD_BGSET = 5;
  localparam int CMD_CSSET = 6;
  localparam int CMD_FULLCAL = 7;
  localparam int CMD_AUDSEND = 8;
  localparam int CMD_LOCCHG = 9;
  localparam int CMD_N = 10;

  // Lamp control bit positions
  localparam int LC_FAULT = 0;
  localparam int LC_DUSTPL = 1;
  localparam int LC_SETRUN = 2;
  localparam int LC_SETPEND = 3;

  // Audit tag kinds
  localparam logic [2:0] TAG_INIT0 = 3'h1;
  localparam logic [2:0] TAG_FINAL0 = 3'h2;
  localparam logic [2:0] TAG_LOW = 3'h3;
  localparam logic [2:0] TAG_MID = 3'h4;
  localparam logic [2:0] TAG_HIGH = 3'h5;

  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] MARK_RST = 16'h0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Times and derived cycle counts at 125 MHz
  localparam longint CLK_KHZ = 125000;
  localparam longint DEB_MS = 10;
  localparam longint HOLD_MS = 1000;
  localparam longint REP_DLY_MS = 500;
  localparam longint REP_MS = 100;
  localparam longint BLINK_MS = 250;
  localparam longint IDLE_MIN = 10;
  localparam int DEB_CYC = int'(DEB_MS * CLK_KHZ);
  localparam int HOLD_CYC = int'(HOLD_MS * CLK_KHZ);
  localparam int REP_DLY_CYC = int'(REP_DLY_MS * CLK_KHZ);
  localparam int REP_CYC = int'(REP_MS * CLK_KHZ);
  localparam int BLINK_CYC = int'(BLINK_MS * CLK_KHZ);
  localparam longint IDLE_CYC = IDLE_MIN * 60 * 1000 * CLK_KHZ;

  function automatic logic [3:0] kdui_max_idx(input kdui_bank_t b);
    case (b)
      BK_U: kdui_max_idx = 4'hb;
      BK_S: kdui_max_idx = 4'he;
      BK_F: kdui_max_idx = 4'hf;
      BK_C: kdui_max_idx = 4'hb;
      default: kdui_max_idx = 4'h8;
    endcase
  endfunction

  // Segments gfedcba, active high
  function automatic logic [6:0] kdui_hex_seg(input logic [3:0] h);
    case (h)
      4'h0: kdui_hex_seg = 7'h3f;
      4'h1: kdui_hex_seg = 7'h06;
      4'h2: kdui_hex_seg = 7'h5b;
      4'h3: kdui_hex_seg = 7'h4f;
      4'h4: kdui_hex_seg = 7'h66;
      4'h5: kdui_hex_seg = 7'h6d;
      4'h6: kdui_hex_seg = 7'h7d;
      4'h7: kdui_hex_seg = 7'h07;
      4'h8: kdui_hex_seg = 7'h7f;
      4'h9: kdui_hex_seg = 7'h6f;
      4'ha: kdui_hex_seg = 7'h77;
      4'hb: kdui_hex_seg = 7'h7c;
      4'hc: kdui_hex_seg = 7'h39;
      4'hd: kdui_hex_seg = 7'h5e;
      4'he: kdui_hex_seg = 7'h79;
      default: kdui_hex_seg = 7'h71;
    endcase
  endfunction
endpackage

// >>> kdui_debounce.sv
// Key synchroniser and debouncer
`timescale 1ns/10ps
module kdui_debounce
  import kdui_pkg::*;
#(
  parameter int CYCLES = DEB_CYC
)(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic key_n_i,
  output logic down_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic stable;
    logic [31:0] cnt;
  } kdui_deb_t;

  kdui_deb_t r;
  kdui_deb_t n;

  always_comb
  begin
    n = r;
    n.s1 = key_n_i;
    n.s2 = r.s1;
    if (r.s2 == r.stable)
    begin
      n.cnt = '0;
    end
    else if (r.cnt == 32'(CYCLES - 1))
    begin
      n.stable = r.s2;
      n.cnt = '0;
    end
    else
    begin
      n.cnt = r.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '{s1: 1'b1, s2: 1'b1, stable: 1'b1, cnt: '0};
    end
    else
    begin
      r <= n;
    end
  end

  assign down_o = ~r.stable;
endmodule

// >>> kdui_top.sv
// Keypad decoding, display drive, lamps and register slave of the panel
// How it works
// RULE1 - Six characters: two location, four value
// RULE2 - Bank letter then index within bank
// RULE3 - Set alone stores value; data ignored
// RULE4 - Up/down step digit, repeat, not data
// RULE5 - Left picks column; with step key, bank
// RULE6 - Step key plus up/down moves index
// RULE7 - One second hold toggles; idle returns user
// RULE8 - Upscale, zero, normal keys start modes
// RULE9 - Set with zero/background/normal start sets
// RULE10 - Upscale with zero starts full cycle
// RULE11 - Audit alone toggles average and marker
// RULE12 - Audit zero tags initial or final zero
// RULE13 - Audit normal tags low filter, run
// RULE14 - Audit upscale tags mid filter, run
// RULE15 - Audit background tags high filter, run
// RULE16 - Tagged value sent on next set
// RULE17 - Cal lamp steady or blinking by position
// RULE18 - Fault lamp on fault, power lamp on
// RULE19 - Set lamp steady when running, blink pending
// RULE20 - Decode mechanism encoder position
// RULE21 - User slots fixed; data not editable
// RULE22 - Marker digits hold run and filter
// RULE23 - Debounce keys; chords never act singly; up/down landing before step key still steps digit if editable
`timescale 1ns/10ps
module kdui_top
  import kdui_pkg::*;
#(
  parameter int DEB_CYCLES = DEB_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int REP_DLY_CYCLES = REP_DLY_CYC,
  parameter int REP_CYCLES = REP_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter longint IDLE_CYCLES = IDLE_CYC
)(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [KEY_N-1:0] key_n_i,
  input wire logic [1:0] enc_i,
  output logic [SEG_W-1:0] seg_o,
  output logic lamp_cal_o,
  output logic lamp_fault_o,
  output logic lamp_set_o,
  output logic lamp_power_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic [KEY_N-1:0] key_q;
    logic chord;
    kdui_bank_t bank;
    logic [3:0] idx;
    logic [1:0] col;
    logic [15:0] edit;
    logic [15:0] data;
    logic [CMD_N-1:0] cmd;
    logic [3:0] lamp;
    logic [15:0] mark;
    logic tag_pend;
    logic [2:0] tag_kind;
    logic [3:0] tag_run;
    logic [6:0] st_loc;
    logic [15:0] st_val;
    logic hold_arm;
    logic [31:0] hold_cnt;
    logic [31:0] rep_cnt;
    logic [39:0] idle_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic [1:0] enc_s1;
    logic [1:0] enc_s2;
    logic [SEG_W-1:0] seg;
    logic [3:0] lamps;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } kdui_state_t;

  kdui_state_t r;
  kdui_state_t n;
  logic [KEY_N-1:0] deb;
  logic [KEY_N-1:0] press;
  logic [KEY_N-1:0] rel;
  logic solo;
  logic any_press;
  logic ro_loc;
  logic wr_go;
  logic [31:0] rd;
  logic rd_err;
  logic [15:0] shown;
  logic [3:0] run;

  genvar gk;
  generate
    for (gk = 0; gk < KEY_N; gk++)
    begin : g_deb
      kdui_debounce #(
        .CYCLES(DEB_CYCLES)
      ) u_deb (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .key_n_i(key_n_i[gk]),
        .down_o(deb[gk])
      );
    end
  endgenerate

  function automatic logic [KEY_N-1:0] km(input int a, input int b);
    km = '0;
    km[a] = 1'b1;
    km[b] = 1'b1;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] st);
    for (int i = 0; i < 4; i++)
    begin
      wmerge[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // One BCD digit up or down, wrapping within the digit
  function automatic logic [15:0] dstep(input logic [15:0] v,
    input logic [1:0] c, input logic up);
    logic [3:0] d;
    dstep = v;
    d = v[c*4 +: 4];
    if (up)
    begin
      d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
    end
    else
    begin
      d = (d == 4'h0 || d > 4'h9) ? 4'h9 : d - 4'h1;
    end
    dstep[c*4 +: 4] = d;
  endfunction

  assign press = deb & ~r.key_q;
  assign rel = ~deb & r.key_q;
  assign any_press = press != '0;
  // Single-key action only on release of a lone, unchorded key
  assign solo = $onehot(rel) && deb == '0 && !r.chord; // RULE23
  assign ro_loc = r.bank == BK_U || r.bank == BK_S; // RULE21
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !r.bvalid;
  assign run = r.mark[15:12];
  assign shown = ro_loc ? r.data : r.edit;

  always_comb
  begin
    rd = 32'h0;
    rd_err = 1'b0;
    if (s_axi_araddr == OFS_LOC)
    begin
      rd = {19'h0, r.tag_pend, r.enc_s2, r.col, r.idx, 1'b0, r.bank};
    end
    else if (s_axi_araddr == OFS_DATA)
    begin
      rd = {16'h0, r.data};
    end
    else if (s_axi_araddr == OFS_EDIT)
    begin
      rd = {16'h0, r.edit};
    end
    else if (s_axi_araddr == OFS_CMD)
    begin
      rd = {22'h0, r.cmd};
    end
    else if (s_axi_araddr == OFS_LAMP)
    begin
      rd = {28'h0, r.lamp};
    end
    else if (s_axi_araddr == OFS_MARK)
    begin
      rd = {16'h0, r.mark};
    end
    else if (s_axi_araddr == OFS_TAG)
    begin
      rd = {24'h0, r.tag_run, r.tag_kind, r.tag_pend};
    end
    else if (s_axi_araddr == OFS_STORE)
    begin
      rd = {9'h0, r.st_loc, r.st_val};
    end
    else
    begin
      rd_err = 1'b1;
    end
  end

  always_comb
  begin
    n = r;
    n.key_q = deb;
    n.enc_s1 = enc_i;
    n.enc_s2 = r.enc_s1; // RULE20
    // Register bus, writes first so hardware events win
    if (r.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      n.bvalid = 1'b1;
      n.bresp = RESP_OK;
      if (s_axi_awaddr == OFS_DATA)
      begin
        n.data = 16'(wmerge({16'h0, r.data}, s_axi_wdata, s_axi_wstrb));
        n.edit = n.data;
      end
      else if (s_axi_awaddr == OFS_CMD)
      begin
        n.cmd = r.cmd & ~CMD_N'(wmerge(32'h0, s_axi_wdata, s_axi_wstrb));
      end
      else if (s_axi_awaddr == OFS_LAMP)
      begin
        n.lamp = 4'(wmerge({28'h0, r.lamp}, s_axi_wdata, s_axi_wstrb));
      end
      else if (s_axi_awaddr == OFS_MARK)
      begin
        n.mark = 16'(wmerge({16'h0, r.mark}, s_axi_wdata, s_axi_wstrb));
      end
      else if (s_axi_awaddr != OFS_LOC && s_axi_awaddr != OFS_EDIT &&
        s_axi_awaddr != OFS_TAG && s_axi_awaddr != OFS_STORE)
      begin
        n.bresp = RESP_ERR;
      end
    end
    if (r.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = rd_err ? RESP_ERR : RESP_OK;
    end
    // Chord tracking
    if ($countones(deb) >= 2)
    begin
      n.chord = 1'b1; // RULE23
    end
    else if (deb == '0)
    begin
      n.chord = 1'b0;
    end
    // Lone key actions on release
    if (solo)
    begin
      if (rel[K_SET])
      begin
        if (r.tag_pend)
        begin
          n.tag_pend = 1'b0; // RULE16
          n.cmd[CMD_AUDSEND] = 1'b1; // RULE16
        end
        else if (!ro_loc)
        begin
          n.st_loc = {r.bank, r.idx}; // RULE3
          n.st_val = r.edit; // RULE3
          n.cmd[CMD_STORE] = 1'b1; // RULE3
        end
      end
      if (rel[K_LEFT])
      begin
        n.col = r.col + 2'h1; // RULE5
      end
      if (rel[K_UPSC])
      begin
        n.cmd[CMD_UPCAL] = 1'b1; // RULE8
      end
      if (rel[K_ZERO])
      begin
        n.cmd[CMD_ZCAL] = 1'b1; // RULE8
      end
      if (rel[K_NORM])
      begin
        n.cmd[CMD_NORM] = 1'b1; // RULE8
      end
      if (rel[K_AUDIT])
      begin
        n.cmd[CMD_LOCCHG] = 1'b1;
        if (r.bank == BK_U && r.idx == SELECTABLE_AVERAGE_SLOT)
        begin
          n.bank = BK_F; // RULE11
          n.idx = AUDIT_MARKER_SLOT;
        end
        else
        begin
          n.bank = BK_U; // RULE11
          n.idx = SELECTABLE_AVERAGE_SLOT;
        end
      end
    end
    // Two-key chords, acted on when the second key lands
    if (any_press)
    begin
      if (deb == km(K_SET, K_ZERO))
      begin
        n.cmd[CMD_ZSET] = 1'b1; // RULE9
      end
      if (deb == km(K_SET, K_BGND))
      begin
        n.cmd[CMD_BGSET] = 1'b1; // RULE9
      end
      if (deb == km(K_SET, K_NORM))
      begin
        n.cmd[CMD_CSSET] = 1'b1; // RULE9
      end
      if (deb == km(K_UPSC, K_ZERO))
      begin
        n.cmd[CMD_FULLCAL] = 1'b1; // RULE10
      end
      if (deb == km(K_LOCATION_STEP_KEY, K_UP))
      begin
        n.idx = (r.idx >= kdui_max_idx(r.bank)) ? 4'h0 : r.idx + 4'h1; // RULE6
        n.cmd[CMD_LOCCHG] = 1'b1;
      end
      if (deb == km(K_LOCATION_STEP_KEY, K_DOWN))
      begin
        n.idx = (r.idx == 4'h0) ? kdui_max_idx(r.bank) : r.idx - 4'h1; // RULE6
        n.cmd[CMD_LOCCHG] = 1'b1;
      end
      if (deb == km(K_LOCATION_STEP_KEY, K_LEFT))
      begin
        n.hold_arm = 1'b1;
        n.hold_cnt = '0;
      end
      if (deb == km(K_AUDIT, K_ZERO) && r.mark[11:8] == 4'h0)
      begin
        if (run == 4'h1)
        begin
          n.tag_kind = TAG_INIT0; // RULE12
          n.tag_run = run;
          n.tag_pend = 1'b1;
        end
        else if (run == 4'h5)
        begin
          n.tag_kind = TAG_FINAL0; // RULE12
          n.tag_run = run;
          n.tag_pend = 1'b1;
        end
      end
      if (deb == km(K_AUDIT, K_NORM))
      begin
        n.tag_kind = TAG_LOW; // RULE13
        n.tag_run = run; // RULE13 RULE22
        n.mark[11:8] = 4'h1; // RULE22
        n.tag_pend = 1'b1;
      end
      if (deb == km(K_AUDIT, K_UPSC))
      begin
        n.tag_kind = TAG_MID; // RULE14
        n.tag_run = run; // RULE14
        n.mark[11:8] = 4'h2; // RULE22
        n.tag_pend = 1'b1;
      end
      if (deb == km(K_AUDIT, K_BGND))
      begin
        n.tag_kind = TAG_HIGH; // RULE15
        n.tag_run = run; // RULE15
        n.mark[11:8] = 4'h3; // RULE22
        n.tag_pend = 1'b1;
      end
    end
    // Step key with left: left let go first while step key held, next bank; long hold toggles
    if (r.hold_arm)
    begin
      if (deb == km(K_LOCATION_STEP_KEY, K_LEFT))
      begin
        if (r.hold_cnt == 32'(HOLD_CYCLES - 1))
        begin
          n.hold_arm = 1'b0;
          n.bank = (r.bank == BK_U) ? BK_S : BK_U; // RULE7
          n.idx = 4'h0;
          n.cmd[CMD_LOCCHG] = 1'b1;
        end
        else
        begin
          n.hold_cnt = r.hold_cnt + 32'h1;
        end
      end
      else
      begin
        n.hold_arm = 1'b0;
        if (deb == km(K_LOCATION_STEP_KEY, K_LOCATION_STEP_KEY) && rel[K_LEFT])
        begin
          n.idx = 4'h0;
          n.cmd[CMD_LOCCHG] = 1'b1;
          case (r.bank) // RULE5
            BK_U: n.bank = BK_S;
            BK_S: n.bank = BK_F;
            BK_F: n.bank = BK_C;
            BK_C: n.bank = BK_A;
            default: n.bank = BK_U;
          endcase
        end
      end
    end
    // Lone up or down with auto-repeat
    if (deb == km(K_UP, K_UP) || deb == km(K_DOWN, K_DOWN))
    begin
      n.rep_cnt = r.rep_cnt + 32'h1;
      if (any_press || r.rep_cnt == 32'(REP_DLY_CYCLES - 1))
      begin
        n.rep_cnt = any_press ? 32'h0 : 32'(REP_DLY_CYCLES - REP_CYCLES);
        if (!ro_loc)
        begin
          n.edit = dstep(r.edit, r.col, deb[K_UP]); // RULE4
        end
      end
    end
    else
    begin
      n.rep_cnt = '0;
    end
    // Keypad inactivity returns to the user bank
    if (deb != '0)
    begin
      n.idle_cnt = '0;
    end
    else if (r.idle_cnt == 40'(IDLE_CYCLES - 1))
    begin
      n.idle_cnt = '0;
      if (r.bank != BK_U)
      begin
        n.bank = BK_U; // RULE7
        n.idx = 4'h0;
        n.cmd[CMD_LOCCHG] = 1'b1;
      end
    end
    else
    begin
      n.idle_cnt = r.idle_cnt + 40'h1;
    end
    // Blink timebase for lamps
    if (r.blink_cnt == 32'(BLINK_CYCLES - 1))
    begin
      n.blink_cnt = '0;
      n.blink = ~r.blink;
    end
    else
    begin
      n.blink_cnt = r.blink_cnt + 32'h1;
    end
    // Letter, index, then four value digits
    n.seg[41:35] = (r.bank == BK_U) ? 7'h3e : // RULE1 RULE2
      (r.bank == BK_S) ? kdui_hex_seg(4'h5) :
      (r.bank == BK_F) ? kdui_hex_seg(4'hf) :
      (r.bank == BK_C) ? kdui_hex_seg(4'hc) : kdui_hex_seg(4'ha);
    n.seg[34:28] = kdui_hex_seg(r.idx); // RULE2
    for (int i = 0; i < 4; i++)
    begin
      n.seg[i*7 +: 7] = kdui_hex_seg(shown[i*4 +: 4]); // RULE1
    end
    // Lamps: cal, fault, set, power
    n.lamps[0] = (r.enc_s2 == POS_ZERO || r.enc_s2 == POS_UPSCALE) ||
      (r.enc_s2 == POS_NORMAL && r.lamp[LC_DUSTPL] && r.blink); // RULE17
    n.lamps[1] = r.lamp[LC_FAULT]; // RULE18
    n.lamps[2] = r.lamp[LC_SETRUN] || r.cmd[CMD_STORE] ||
      (r.lamp[LC_SETPEND] && r.blink); // RULE19
    n.lamps[3] = 1'b1; // RULE18
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.bank <= BK_U;
      r.data <= DATA_RST;
      r.edit <= DATA_RST;
      r.mark <= MARK_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign seg_o = r.seg;
  assign lamp_cal_o = r.lamps[0];
  assign lamp_fault_o = r.lamps[1];
  assign lamp_set_o = r.lamps[2];
  assign lamp_power_o = r.lamps[3];
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
endmodule

// >>> kdui_checker.sv
// Port-level assertions for the keypad display control
`timescale 1ns/10ps
module kdui_checker
  import kdui_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] enc_i,
  input wire logic [SEG_W-1:0] seg_o,
  input wire logic lamp_cal_o,
  input wire logic lamp_fault_o,
  input wire logic lamp_power_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking
    @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  AST_POWER: assert property (!$past(rst_i) |-> lamp_power_o)
    else $error("power lamp off");
  AST_LETTER: assert property (!$past(rst_i) |->
    seg_o[41:35] inside {7'h3e, 7'h6d, 7'h71, 7'h39, 7'h77})
    else $error("bad bank letter");
  AST_FAULT: assert property (wr_go && s_axi_awaddr == OFS_LAMP &&
    s_axi_wstrb[0] && s_axi_wdata[0] |-> ##[1:3] lamp_fault_o)
    else $error("fault lamp not lit");
  AST_CAL_ON: assert property (enc_i[1] [*6] |-> lamp_cal_o)
    else $error("cal lamp not steady");
  AST_CAL_OFF: assert property ((enc_i == 2'h0) [*6] |-> !lamp_cal_o)
    else $error("cal lamp lit at unknown position");
  AST_BVALID: assert property (wr_go |=> s_axi_bvalid)
    else $error("no write response");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RVALID: assert property (s_axi_arvalid && !s_axi_rvalid |=>
    s_axi_rvalid)
    else $error("no read response");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_CAL: cover property ($rose(lamp_cal_o));
  COV_FAULT: cover property ($rose(lamp_fault_o));
endmodule

bind kdui_top kdui_checker chk (.core_clk_i, .rst_i, .enc_i, .seg_o,
  .lamp_cal_o, .lamp_fault_o, .lamp_power_o, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// >>> kdui_operator.sv
// Operator model: keypad contacts and mechanism encoder
`timescale 1ns/10ps
module kdui_operator (
  input wire logic core_clk_i,
  output logic [9:0] key_n_o,
  output logic [1:0] enc_o
);
  // Released contacts sit at the pull-up level
  initial
  begin
    key_n_o = 10'h3ff;
    enc_o = 2'h0;
  end
  task automatic press(input logic [9:0] m, input int hold);
    key_n_o <= ~m;
    repeat (hold) @(posedge core_clk_i);
    key_n_o <= 10'h3ff;
    repeat (14) @(posedge core_clk_i);
  endtask
  // Press both keys together, let go of the tapped key, then of the held key
  task automatic roll(input logic [9:0] h, t, input int hold);
    key_n_o <= ~(h | t);
    repeat (hold) @(posedge core_clk_i);
    key_n_o <= ~h;
    repeat (hold) @(posedge core_clk_i);
    key_n_o <= 10'h3ff;
    repeat (14) @(posedge core_clk_i);
  endtask
  task automatic move(input logic [1:0] p);
    enc_o <= p;
    repeat (8) @(posedge core_clk_i);
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the keypad display control
`timescale 1ns/10ps
module testbench;
  import kdui_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] key_n_i;
  logic [1:0] enc_i, s_axi_bresp, s_axi_rresp, r;
  logic [SEG_W-1:0] seg_o;
  logic lamp_cal_o, lamp_fault_o, lamp_set_o, lamp_power_o;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [9:0] km [9];
  logic [9:0] ak [5];
  logic [31:0] ce [9];
  logic [31:0] mk [5];
  logic [31:0] tg [5];
  int mismatches = 0, samples_checked = 0, cycles = 0, hc, hs;

  always #4 core_clk_i = ~core_clk_i;

  kdui_operator op (.core_clk_i, .key_n_o(key_n_i), .enc_o(enc_i));

  kdui_top #(.DEB_CYCLES(4), .HOLD_CYCLES(20), .REP_CYCLES(4),
    .BLINK_CYCLES(4), .IDLE_CYCLES(50)) dut (
    .core_clk_i, .rst_i, .key_n_i, .enc_i, .seg_o, .lamp_cal_o,
    .lamp_fault_o, .lamp_set_o, .lamp_power_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  function automatic logic [9:0] kb(input int i);
    return 10'h001 << i;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge core_clk_i); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge core_clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, m);
    rd(a);
    chk($sformatf("reg %h", a), d & m, e);
  endtask

  task automatic finish_test;
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  initial
  begin
    km = '{kb(K_UPSC), kb(K_ZERO), kb(K_NORM), kb(K_SET) | kb(K_ZERO),
      kb(K_SET) | kb(K_BGND), kb(K_SET) | kb(K_NORM),
      kb(K_UPSC) | kb(K_ZERO), kb(K_BGND), kb(K_SET)};
    ce = '{32'h2, 32'h4, 32'h8, 32'h10, 32'h20, 32'h40, 32'h80, 0, 0};
    ak = '{kb(K_ZERO), kb(K_ZERO), kb(K_NORM), kb(K_UPSC), kb(K_BGND)};
    mk = '{32'h1000, 32'h5000, 32'h2000, 32'h3000, 32'h4000};
    tg = '{32'h13, 32'h55, 32'h27, 32'h39, 32'h4b};
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (60) @(posedge core_clk_i);
    chk("power lamp", lamp_power_o, 1);
    chk("display", seg_o === {7'h3e, {5{7'h3f}}}, 1);
    rd(8'h20);
    chk("rresp", r, RESP_ERR);
    chk("rdata", d, 0);
    wr(8'h20, 32'h1);
    chk("bresp", r, RESP_ERR);
    wr(OFS_CMD, 32'h3ff);
    for (int i = 0; i < 9; i++)
    begin
      op.press(km[i], 12);
      rc(OFS_CMD, ce[i], 32'h3ff);
      wr(OFS_CMD, 32'h3ff);
    end
    wr(OFS_DATA, 32'h1234);
    op.press(kb(K_UP), 8);
    rc(OFS_EDIT, 32'h1234, 32'hffff);
    op.press(kb(K_LOCATION_STEP_KEY) | kb(K_UP), 12);
    rc(OFS_LOC, 32'h10, 32'hff);
    op.press(kb(K_LOCATION_STEP_KEY) | kb(K_DOWN), 12);
    rc(OFS_LOC, 32'h0, 32'hff);
    op.roll(kb(K_LOCATION_STEP_KEY), kb(K_LEFT), 12);
    op.roll(kb(K_LOCATION_STEP_KEY), kb(K_LEFT), 12);
    rc(OFS_LOC, 32'h3, 32'hff);
    op.press(kb(K_UP), 8);
    op.press(kb(K_LEFT), 12);
    op.press(kb(K_UP), 8);
    rc(OFS_EDIT, 32'h1245, 32'hffff);
    rc(OFS_LOC, 32'h103, 32'h3ff);
    op.press(kb(K_SET), 12);
    rc(OFS_STORE, 32'h301245, 32'h7fffff);
    rc(OFS_CMD, 32'h1, 32'h1);
    chk("set lamp", lamp_set_o, 1);
    wr(OFS_CMD, 32'h3ff);
    repeat (60) @(posedge core_clk_i);
    rc(OFS_LOC, 32'h0, 32'hff);
    op.press(kb(K_LOCATION_STEP_KEY) | kb(K_LEFT), 30);
    rc(OFS_LOC, 32'h1, 32'hff);
    op.press(kb(K_AUDIT), 12);
    rc(OFS_LOC, 32'h20, 32'hff);
    op.press(kb(K_AUDIT), 12);
    rc(OFS_LOC, 32'h43, 32'hff);
    for (int i = 0; i < 5; i++)
    begin
      wr(OFS_MARK, mk[i]);
      op.press(kb(K_AUDIT) | ak[i], 12);
      rc(OFS_TAG, tg[i], 32'hff);
    end
    op.press(kb(K_SET), 12);
    rc(OFS_CMD, 32'h100, 32'h101);
    wr(OFS_LAMP, 32'h1);
    repeat (3) @(posedge core_clk_i);
    chk("fault lamp", lamp_fault_o, 1);
    op.move(POS_ZERO);
    chk("cal lamp", lamp_cal_o, 1);
    rc(OFS_LOC, 32'h800, 32'hc00);
    op.move(POS_NORMAL);
    wr(OFS_LAMP, 32'ha);
    hc = 0;
    hs = 0;
    repeat (16)
    begin
      @(posedge core_clk_i);
      hc += (lamp_cal_o === 1'b1);
      hs += (lamp_set_o === 1'b1);
    end
    chk("cal blink", hc > 0 && hc < 16, 1);
    chk("set blink", hs > 0 && hs < 16, 1);
    wr(OFS_LAMP, 32'h4);
    repeat (3) @(posedge core_clk_i);
    chk("set steady", lamp_set_o, 1);
    finish_test();
  end
endmodule
